// ### hdl/i2c_key_pkg.sv
// Constants for the keyed I2C slave register port.
// Assumes a single 100 MHz system clock; bus pins arrive asynchronously.
// Contract
// R01: Slave up to 400 kbit/s, auto-increment.
// R02: Master makes SCL; SDA bidirectional.
// R03: SDA open-drain, pulled low or released.
// R04: SDA falling while SCL high starts.
// R05: SDA rising while SCL high stops.
// R06: SDA changes only while SCL low.
// R07: Match address, acknowledge, take sub-address.
// R08: Acknowledge address, sub-address, data bytes.
// R09: Register address increments per data byte.
// R10: Stop or data word ends transaction; the code ends it on a stop or a repeated start, not on a data byte.
// R11: Writes 0x0B to 0x1F need key; the code writes 0x0B, the key register, without the key.
// R12: Reads never need the key.
// R13: Key clears after the following transaction.
// R14: Master writes key as address XOR 0x7D.
// R15: Single-confirm write needs key XOR address 0x7D.
// R16: Double-confirm first keyed write only stored.
// R17: Double-confirm updates on two matching keyed writes.
// R18: Intervening transaction abandons double-confirm.
// R19: Reset events restore every register default.
// R20: Reads shift MSB first, stop on NACK.
// R21: Fixed seven-bit address, sample direction bit.
`default_nettype none
package i2c_key_pkg;
   localparam logic [7:0] KEY_REG_ADDR   = 8'h0B; // Key register offset
   localparam logic [7:0] PROT_LO        = 8'h0B; // First protected offset
   localparam logic [7:0] PROT_HI        = 8'h1F; // Last protected offset
   localparam logic [7:0] KEY_MAGIC      = 8'h7D; // Key XOR constant
   localparam logic [7:0] KEY_RESET      = 8'h00; // Key value when cleared
   localparam logic [7:0] REG_RESET      = 8'h00; // Default register value
   localparam int         NUM_REGS       = 32;    // Registers in the file
   localparam logic [6:0] DEF_SLAVE_ADDR = 7'h42; // Plain default address
   localparam logic [31:0] SINGLE_MASK   = 32'h7E402000; // Single-confirm map
   localparam logic [31:0] DOUBLE_MASK   = 32'h003FC000; // Double-confirm map
endpackage
`default_nettype wire

// ### hdl/i2c_slave_with_write_key.sv
// I2C slave port with keyed write protection over a 32-byte register file.
// Assumes SCL and SDA are asynchronous pins and a pull-up exists on SDA.
// Reset strobes from the power controller restore register, key and hold-flag defaults; bus state and pointer are not reset.
`default_nettype none
module i2c_slave_with_write_key #(
   parameter logic [6:0] SLAVE_ADDR = i2c_key_pkg::DEF_SLAVE_ADDR
) (
   input  wire logic        ref_clk_i,     // 100 MHz system clock
   input  wire logic        sys_rst_i,     // Async reset, active high
   input  wire logic        scl_i,         // Bus clock pin
   input  wire logic        sda_i,         // Bus data pin level
   output logic             sda_o,         // Data drive value, always 0
   output logic             sda_oe_n_o,    // Low while pulling SDA low
   input  wire logic        sleep_entry_i, // Active left for sleep/off
   input  wire logic        por_i,         // Power-on reset strobe
   input  wire logic        button_long_i, // Push-button held over 8 s
   input  wire logic        hardware_reset_pin_n, // Reset pin, active low
   input  wire logic        fault_i,       // Fault strobe
   output logic [255:0]     regs_o         // Flat register file contents
);
   // Two-flop synchronisers; first stage is read only by the second
   logic [1:0] scl_sync;      // SCL synchroniser
   logic [1:0] sda_sync;      // SDA synchroniser
   logic [1:0] hrst_sync;     // Reset pin synchroniser
   logic       scl_d;         // Previous synced SCL
   logic       sda_d;         // Previous synced SDA
   logic [7:0] regs [i2c_key_pkg::NUM_REGS]; // Register storage
   logic [7:0] key;           // Key register
   logic       key_armed;     // Key written, set at the write, not yet cleared
   logic       key_used;      // The key write's own transaction has ended
   logic [7:0] hold_data;     // Double-confirm temporary data
   logic [7:0] hold_addr;     // Address the held data belongs to
   logic       hold_valid;    // First keyed write is pending
   logic       hold_fresh;    // Held data set in this transaction
   logic [7:0] shreg;         // Receive/transmit shift register
   logic [3:0] bitcnt;        // Bit counter in a byte
   logic [7:0] ptr;           // Register address pointer
   logic       rd_mode;       // Direction bit of current transfer
   logic       busy;          // Inside an addressed transaction
   logic       byte_nack;     // Master NACKed during a read

   // Slave ack states share one branch; read data follows the address ack
   typedef enum {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SUB, ST_SUB_ACK,
      ST_WDATA, ST_WACK, ST_RDATA, ST_RACK
   } state_t;
   state_t state;             // Protocol state

   // Bus edge and condition decode from synced pins
   wire scl_rise   = scl_sync[1] & ~scl_d;
   wire scl_fall   = ~scl_sync[1] & scl_d;
   wire start_cond = scl_sync[1] & scl_d & sda_d & ~sda_sync[1]; // R04
   wire stop_cond  = scl_sync[1] & scl_d & ~sda_d & sda_sync[1]; // R05
   wire reset_evt  = sleep_entry_i | por_i | button_long_i |
                     ~hrst_sync[1] | fault_i;                   // R19

   // Protection class decode, shared by the write path
   // Offsets outside the file belong to neither class
   function automatic logic is_single(input logic [7:0] a);
      is_single = (a < 8'(i2c_key_pkg::NUM_REGS)) &&
                  i2c_key_pkg::SINGLE_MASK[a[4:0]];
   endfunction
   function automatic logic is_double(input logic [7:0] a);
      is_double = (a < 8'(i2c_key_pkg::NUM_REGS)) &&
                  i2c_key_pkg::DOUBLE_MASK[a[4:0]];
   endfunction

   wire [7:0] rx_byte   = {shreg[6:0], sda_sync[1]};   // Byte at 8th bit
   wire       key_ok    = key_armed &&
                          ((key ^ ptr) == i2c_key_pkg::KEY_MAGIC); // R15
   // Key armed but not yet counted: this transaction wrote it
   wire       key_txn   = key_armed && !key_used;                 // R18
   wire       in_prot   = (ptr >= i2c_key_pkg::PROT_LO) &&
                          (ptr <= i2c_key_pkg::PROT_HI) &&
                          (ptr != i2c_key_pkg::KEY_REG_ADDR);      // R11
   wire       single_wr = is_single(ptr);
   wire       double_wr = is_double(ptr);
   wire       open_wr   = !in_prot && (ptr < 8'(i2c_key_pkg::NUM_REGS));
   wire       dbl_match = hold_valid && (hold_addr == ptr) &&
                          (hold_data == rx_byte);                  // R17
   // Offsets past the file read as zero; writes there are dropped
   wire [7:0] rd_byte   = (ptr < 8'(i2c_key_pkg::NUM_REGS)) ?
                          ((ptr == i2c_key_pkg::KEY_REG_ADDR) ? key :
                           regs[ptr[4:0]]) : 8'h00;                // R12
   // Only an addressed transfer counts; a foreign address is ignored
   wire       txn_end   = busy && (stop_cond || start_cond);       // R10

   // Flatten register file onto the output bus
   genvar gi;
   generate
      for (gi = 0; gi < i2c_key_pkg::NUM_REGS; gi++)
      begin : g_flat
         assign regs_o[gi*8 +: 8] = regs[gi];
      end
   endgenerate

   // Pin synchronisers and edge history; reset values match the idle
   // high bus, so that no false edge follows reset
   // The data drive value is a flop as well, held low for open drain
   always_ff @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         scl_sync  <= 2'h3;
         sda_sync  <= 2'h3;
         hrst_sync <= 2'h3;
         scl_d     <= 1'b1;
         sda_d     <= 1'b1;
         sda_o     <= 1'b0;
      end
      else
      begin
         scl_sync  <= {scl_sync[0], scl_i};
         sda_sync  <= {sda_sync[0], sda_i};
         hrst_sync <= {hrst_sync[0], hardware_reset_pin_n};
         scl_d     <= scl_sync[1];
         sda_d     <= sda_sync[1];
         sda_o     <= 1'b0;                                     // R03
      end
   end

   // Protocol engine; sda changes only after SCL falls
   always_ff @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         state      <= ST_IDLE;
         shreg      <= 8'h00;
         bitcnt     <= 4'h0;
         ptr        <= 8'h00;
         rd_mode    <= 1'b0;
         busy       <= 1'b0;
         byte_nack  <= 1'b0;
         sda_oe_n_o <= 1'b1;
      end
      else if (start_cond)
      begin
         // Repeated start keeps the pointer for combined transfers
         // A start inside a byte drops that byte; nothing is written
         state      <= ST_ADDR;                                 // R04
         bitcnt     <= 4'h0;
         sda_oe_n_o <= 1'b1;
         busy       <= 1'b0;
      end
      else if (stop_cond)
      begin
         // Stop ends the transfer; the pointer stays for the next one
         state      <= ST_IDLE;                                 // R05
         sda_oe_n_o <= 1'b1;
         busy       <= 1'b0;
      end
      else
      begin
         unique case (state)
            ST_IDLE:
            begin
               // Silent until the next start, also after a foreign address
               sda_oe_n_o <= 1'b1;
            end
            ST_ADDR, ST_SUB, ST_WDATA:
            begin
               // Sample on SCL rising edge
               if (scl_rise)
               begin
                  shreg  <= rx_byte;
                  bitcnt <= bitcnt + 4'h1;
                  if (bitcnt == 4'h7)
                  begin
                     if (state == ST_ADDR)
                     begin
                        if (rx_byte[7:1] == SLAVE_ADDR)        // R21
                        begin
                           rd_mode <= rx_byte[0];             // R21
                           busy    <= 1'b1;
                           state   <= ST_ADDR_ACK;            // R07
                        end
                        else
                           state <= ST_IDLE;                  // R07
                     end
                     else if (state == ST_SUB)
                        state <= ST_SUB_ACK;
                     else
                        state <= ST_WACK;
                  end
               end
               // The ack itself is driven from the ack states below
            end
            ST_ADDR_ACK, ST_SUB_ACK, ST_WACK:
            begin
               // First fall after bit 8 pulls the line low for the ack.
               // Count 9 marks the ack clock, so that the next fall ends
               // it; without it the ack would be driven again for ever
               if (scl_fall && bitcnt == 4'h8)
               begin
                  sda_oe_n_o <= 1'b0;                         // R03 R08
                  bitcnt     <= 4'h9;
               end
               else if (scl_fall)
               begin
                  // End of ack clock: release or load read data
                  bitcnt <= 4'h0;
                  if (state == ST_SUB_ACK)
                     ptr <= shreg;                            // R07
                  if (state == ST_WACK)
                     ptr <= ptr + 8'h01;                      // R09
                  if (state == ST_ADDR_ACK && rd_mode)
                  begin
                     shreg      <= rd_byte;                   // R20
                     sda_oe_n_o <= rd_byte[7];
                     bitcnt     <= 4'h1;
                     state      <= ST_RDATA;
                  end
                  else
                  begin
                     sda_oe_n_o <= 1'b1;
                     state <= (state == ST_ADDR_ACK) ? ST_SUB : ST_WDATA;
                  end
               end
            end
            ST_RDATA:
            begin
               // Shift MSB first on each falling edge
               if (scl_fall)
               begin
                  // Count 8: all bits are out; free the line for the master
                  if (bitcnt == 4'h8)
                  begin
                     sda_oe_n_o <= 1'b1;
                     state      <= ST_RACK;
                     ptr        <= ptr + 8'h01;               // R09
                  end
                  else
                  begin
                     sda_oe_n_o <= shreg[3'(4'h7 - bitcnt)];   // R20
                     bitcnt     <= bitcnt + 4'h1;
                  end
               end
            end
            ST_RACK:
            begin
               // Master ack sampled on rise; NACK ends driving
               if (scl_rise)
                  byte_nack <= sda_sync[1];
               if (scl_fall)
               begin
                  // NACK stops driving; an ACK loads the next register
                  if (byte_nack)
                     state <= ST_IDLE;                        // R20
                  else
                  begin
                     shreg      <= rd_byte;
                     sda_oe_n_o <= rd_byte[7];
                     bitcnt     <= 4'h1;
                     state      <= ST_RDATA;
                  end
               end
            end
         endcase
      end
   end

   // Write effect at eighth data bit of a write byte
   // Gated off start and stop, so a cut byte never reaches a register
   wire wr_strobe = (state == ST_WDATA) && scl_rise && (bitcnt == 4'h7)
                    && !start_cond && !stop_cond;

   // Register file, key and double-confirm store
   always_ff @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         for (int i = 0; i < i2c_key_pkg::NUM_REGS; i++)
            regs[i] <= i2c_key_pkg::REG_RESET;
         key        <= i2c_key_pkg::KEY_RESET;
         key_armed  <= 1'b0;
         key_used   <= 1'b0;
         hold_data  <= 8'h00;
         hold_addr  <= 8'h00;
         hold_valid <= 1'b0;
         hold_fresh <= 1'b0;
      end
      else if (reset_evt)
      begin
         // Any power event wipes registers, key and hold flags back to defaults
         // Events win over a bus write that lands in the same cycle
         for (int i = 0; i < i2c_key_pkg::NUM_REGS; i++)
            regs[i] <= i2c_key_pkg::REG_RESET;                // R19
         key        <= i2c_key_pkg::KEY_RESET;
         key_armed  <= 1'b0;
         key_used   <= 1'b0;
         hold_valid <= 1'b0;
         hold_fresh <= 1'b0;
      end
      else if (txn_end)
      begin
         // Key write arms; the next transaction consumes it
         if (key_used)
         begin
            key       <= i2c_key_pkg::KEY_RESET;              // R13
            key_armed <= 1'b0;
            key_used  <= 1'b0;
         end
         else if (key_armed)
            key_used <= 1'b1;
         // A pending first write survives its own transaction and the
         // key write that follows it; any other transaction drops it
         if (!hold_fresh && !key_txn)
            hold_valid <= 1'b0;                               // R18
         hold_fresh <= 1'b0;
      end
      else if (wr_strobe)
      begin
         if (ptr == i2c_key_pkg::KEY_REG_ADDR)
         begin
            key       <= rx_byte;                             // R14
            key_armed <= 1'b1;
            key_used  <= 1'b0;
         end
         else if (open_wr)
            regs[ptr[4:0]] <= rx_byte;                        // R11
         else if (single_wr && key_ok)
            regs[ptr[4:0]] <= rx_byte;                        // R15
         else if (double_wr && key_ok && dbl_match)
         begin
            regs[ptr[4:0]] <= rx_byte;                        // R17
            hold_valid     <= 1'b0;
         end
         else if (double_wr && key_ok)
         begin
            hold_data  <= rx_byte;                            // R16
            hold_addr  <= ptr;
            hold_valid <= 1'b1;
            hold_fresh <= 1'b1;
         end
         else if (double_wr)
            hold_valid <= 1'b0;                               // R17
      end
   end

   // R01 R02 R06: sampling at 100 MHz resolves 400 kHz edges easily;
   // a glitch shorter than two clocks can still slip through, since
   // the block has no spike filter of its own
endmodule
`default_nettype wire

// ### verification/i2c_key_checker.sv
// Pin-level checks for the keyed I2C slave port.
// Assumes binding onto the slave's top module; one clock domain.
`default_nettype none
module i2c_key_checker (
   input wire logic         ref_clk_i,     // System clock
   input wire logic         sys_rst_i,     // Async reset
   input wire logic         scl_i,         // Bus clock pin
   input wire logic         sda_o,         // Data drive value
   input wire logic         sda_oe_n_o,    // Drive enable, low
   input wire logic         sleep_entry_i, // Sleep strobe
   input wire logic         por_i,         // Power-on strobe
   input wire logic         button_long_i, // Long press strobe
   input wire logic         hardware_reset_pin_n, // Reset pin
   input wire logic         fault_i,       // Fault strobe
   input wire logic [255:0] regs_o         // Register file
);
   timeunit 1ns;
   timeprecision 1ns;
   // All checks share the system clock and its reset
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   chk_drive_zero: assert property (sda_o == 1'b0)
      else $error("Data drive value not low");
   chk_quiet_high: assert property ($changed(sda_oe_n_o) |-> !scl_i)
      else $error("Data drive moved while clock high");
   // Ack or data bit held low for at least eight clocks after the drive falls
   chk_ack_stands: assert property (
      $fell(sda_oe_n_o) |-> !sda_oe_n_o [*8])
      else $error("Drive released too early");
   chk_por_clear: assert property (por_i |-> ##[1:2] regs_o == '0)
      else $error("Power-on strobe left registers set");
   chk_fault_clear: assert property (fault_i |-> ##[1:2] regs_o == '0)
      else $error("Fault strobe left registers set");
   chk_sleep_clear: assert property (
      sleep_entry_i |-> ##[1:2] regs_o == '0)
      else $error("Sleep strobe left registers set");
   chk_button_clear: assert property (
      button_long_i |-> ##[1:2] regs_o == '0)
      else $error("Button strobe left registers set");
   // Pin passes a two-flop synchroniser first
   chk_pin_clear: assert property (
      $fell(hardware_reset_pin_n) |-> ##[1:4] regs_o == '0)
      else $error("Reset pin left registers set");

   cov_ack: cover property ($fell(sda_oe_n_o));
   cov_write: cover property ($changed(regs_o) && !por_i);
   cov_por: cover property (por_i);
   cov_pin: cover property ($fell(hardware_reset_pin_n));
endmodule

bind i2c_slave_with_write_key i2c_key_checker u_i2c_key_checker (
   .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl_i),
   .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .sleep_entry_i(sleep_entry_i),
   .por_i(por_i), .button_long_i(button_long_i), .fault_i(fault_i),
   .hardware_reset_pin_n(hardware_reset_pin_n), .regs_o(regs_o));
`default_nettype wire

// ### verification/i2c_master_model.sv
// Behavioural bus master: makes SCL, pulls SDA low or lets it go.
// Assumes the bench resolves SDA with a pull-up; calls begin at a clk fall.
`default_nettype none
module i2c_master_model (
   input  wire logic sda_i,    // Resolved data line
   output logic      scl_o,    // Bus clock, still outside frames
   output logic      sda_low_o // High while pulling SDA low
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int Q = 40; // Quarter of the 160 ns bus period
   // Bus idles released
   initial
   begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   // Start or repeated start; extra quarter lets a slave ack end
   task automatic start();
      #Q sda_low_o = 1'b0;
      #Q scl_o = 1'b1;
      #Q sda_low_o = 1'b1;
      #Q scl_o = 1'b0;
   endtask
   // Data only moves while the clock is low
   task automatic bit_io(input logic b, output logic s);
      #Q sda_low_o = !b;
      #Q scl_o = 1'b1;
      #Q s = sda_i;
      #Q scl_o = 1'b0;
   endtask
   // Byte out, MSB first, then sample the slave's ack
   task automatic put(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(d[i], s);
      bit_io(1'b1, ack);
   endtask
   // Byte in; last set answers with a not-acknowledge
   task automatic get(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(last, s);
   endtask
   task automatic stop();
      #Q sda_low_o = 1'b1;
      #Q scl_o = 1'b1;
      #Q sda_low_o = 1'b0;
      #Q;
   endtask
endmodule
`default_nettype wire

// ### verification/i2c_slave_with_write_key_tb.sv
// Self-checking bench for the keyed I2C slave port.
// Assumes the package, master model and checker are compiled first.
`default_nettype none
module i2c_slave_with_write_key_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] ADW = {i2c_key_pkg::DEF_SLAVE_ADDR, 1'b0};
   logic         clk;           // System clock
   logic         rst;           // Reset, active high
   logic [4:0]   strobe;        // Sleep, por, button, fault, pin
   logic         scl;           // Bus clock from master
   logic         m_low;         // Master pulling SDA
   logic         sda_drv;       // Slave drive value
   logic         oe_n;          // Slave drive enable, low
   logic [255:0] regs;          // Register file view
   wire logic    sda;           // Resolved data line
   int           errors = 0;    // Mismatches
   int           cmp_count = 0; // Comparisons
   int           cycles = 0;    // Timeout counter
   // Pull-up wins unless someone pulls low
   assign sda = !m_low && (oe_n || sda_drv);

   i2c_slave_with_write_key u_i2c_slave_with_write_key (
      .ref_clk_i(clk), .sys_rst_i(rst), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_drv), .sda_oe_n_o(oe_n), .sleep_entry_i(strobe[0]),
      .por_i(strobe[1]), .button_long_i(strobe[2]), .fault_i(strobe[3]),
      .hardware_reset_pin_n(!strobe[4]), .regs_o(regs));
   i2c_master_model u_mst (.sda_i(sda), .scl_o(scl), .sda_low_o(m_low));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = !clk;
   end
   // Hang guard, well above the expected run
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         errors++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("Counts: %0d compares, %0d mismatches", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] rg(input logic [7:0] a);
      return regs[8*int'(a) +: 8];
   endfunction
   // One-byte write transaction, all three acks expected
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic k0, k1, k2;
      u_mst.start();
      u_mst.put(ADW, k0);
      u_mst.put(a, k1);
      u_mst.put(d, k2);
      u_mst.stop();
      chk({5'h00, k0, k1, k2}, 8'h00);
   endtask
   // Pointer set, repeated start, two bytes read, NACK ends
   task automatic rd(input logic [7:0] a, output logic [7:0] d0,
                     output logic [7:0] d1);
      logic k0, k1, k2;
      u_mst.start();
      u_mst.put(ADW, k0);
      u_mst.put(a, k1);
      u_mst.start();
      u_mst.put(ADW | 8'h01, k2);
      u_mst.get(1'b0, d0);
      u_mst.get(1'b1, d1);
      u_mst.stop();
      chk({5'h00, k0, k1, k2}, 8'h00);
      chk({7'h00, sda}, 8'h01);
   endtask
   task automatic key(input logic [7:0] a);
      wr(i2c_key_pkg::KEY_REG_ADDR, a ^ i2c_key_pkg::KEY_MAGIC);
   endtask

   // Burst write then burst read of neighbours
   task automatic t_basic();
      logic [7:0] d0, d1;
      logic k0, k1, k2, k3;
      u_mst.start();
      u_mst.put(ADW, k0);
      u_mst.put(8'h03, k1);
      u_mst.put(8'hA5, k2);
      u_mst.put(8'h5A, k3);
      u_mst.stop();
      chk({4'h0, k0, k1, k2, k3}, 8'h00);
      chk(rg(8'h04), 8'h5A);
      rd(8'h03, d0, d1);
      chk(d0, 8'hA5);
      chk(d1, 8'h5A);
      $display("t_basic done");
   endtask
   // Foreign address gets no ack
   task automatic t_addr();
      logic k;
      u_mst.start();
      u_mst.put({7'h25, 1'b0}, k);
      u_mst.stop();
      chk({7'h00, k}, 8'h01);
      $display("t_addr done");
   endtask
   // Single-confirm register 0x0D
   task automatic t_single();
      logic [7:0] d0, d1;
      wr(8'h0D, 8'h11);
      chk(rg(8'h0D), 8'h00);
      key(8'h0D);
      wr(8'h0D, 8'h22);
      chk(rg(8'h0D), 8'h22);
      rd(8'h0B, d0, d1);
      chk(d0, 8'h00);
      key(8'h0D);
      rd(8'h00, d0, d1);
      wr(8'h0D, 8'h33);
      chk(rg(8'h0D), 8'h22);
      rd(8'h0C, d0, d1);
      chk(d1, 8'h22);
      $display("t_single done");
   endtask
   // Double-confirm register 0x0E
   task automatic t_double();
      key(8'h0E);
      wr(8'h0E, 8'h44);
      chk(rg(8'h0E), 8'h00);
      key(8'h0E);
      wr(8'h0E, 8'h44);
      chk(rg(8'h0E), 8'h44);
      key(8'h0E);
      wr(8'h0E, 8'h55);
      key(8'h0E);
      wr(8'h0E, 8'h66);
      chk(rg(8'h0E), 8'h44);
      key(8'h0E);
      wr(8'h0E, 8'h55);
      wr(8'h05, 8'h01);
      key(8'h0E);
      wr(8'h0E, 8'h55);
      chk(rg(8'h0E), 8'h44);
      $display("t_double done");
   endtask
   // Each reset event clears open register 0x05; protected 0x0E is set only before the first
   task automatic t_reset();
      for (int i = 0; i < 5; i++)
      begin
         wr(8'h05, 8'h3C);
         @(negedge clk) strobe[i] = 1'b1;
         repeat (4) @(negedge clk);
         strobe = 5'h00;
         repeat (2) @(negedge clk);
         chk(rg(8'h05), 8'h00);
         chk(rg(8'h0E), 8'h00);
      end
      $display("t_reset done");
   endtask

   initial
   begin
      rst = 1'b1;
      strobe = 5'h00;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      chk(rg(8'h0D), 8'h00);
      t_basic();
      t_addr();
      t_single();
      t_double();
      t_reset();
      complete_run();
   end
endmodule
`default_nettype wire
